// File: hdl/uwf_pkg.sv
package uwf_pkg;
    // register word offsets (byte addresses)
    localparam logic [4:0] ADDR_DATA = 5'h00;
    localparam logic [4:0] ADDR_LCR = 5'h04;
    localparam logic [4:0] ADDR_FCR = 5'h08;
    localparam logic [4:0] ADDR_DIV = 5'h0C;
    localparam logic [4:0] ADDR_STAT = 5'h10;
    localparam logic [4:0] ADDR_MASK = 5'h14;
    localparam logic [4:0] ADDR_IID = 5'h18;
    // line control fields
    localparam int LCR_WLEN_LSB = 0;
    localparam int LCR_STOP_BIT = 2;
    localparam int LCR_PEN_BIT = 3;
    localparam int LCR_EPS_BIT = 4;
    localparam int LCR_STICK_BIT = 5;
    localparam int LCR_SRC16_BIT = 6;
    // fifo control fields
    localparam int FCR_EN_BIT = 0;
    localparam int FCR_TRIG_LSB = 6;
    // status / mask bits
    localparam int ST_RXDATA = 0;
    localparam int ST_THRE = 1;
    localparam int ST_TIMEOUT = 2;
    localparam int ST_PARITY = 3;
    localparam int ST_FRAME = 4;
    localparam int ST_OVERRUN = 5;
    localparam int ST_BITS = 6;
    // reset values
    localparam logic [7:0] LCR_RESET = 8'h03;
    localparam logic [7:0] FCR_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [5:0] MASK_RESET = 6'h00;
    // fifo geometry
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    // baud source rates and the system clock
    localparam int CLK_HZ = 100_000_000;
    localparam int SRC24_HZ = 24_000_000;
    localparam int SRC16_HZ = 16_000_000;
    localparam int OVERSAMPLE = 16;
    localparam int FILTER_TICKS = 2;
    localparam int TIMEOUT_CHARS = 4;
    // interrupt identification codes, highest priority first
    localparam logic [2:0] IID_NONE = 3'h0;
    localparam logic [2:0] IID_LINE = 3'h1;
    localparam logic [2:0] IID_RXDATA = 3'h2;
    localparam logic [2:0] IID_TIMEOUT = 3'h3;
    localparam logic [2:0] IID_THRE = 3'h4;
endpackage

// File: hdl/uwf_uart.sv
`timescale 1ns/100ps
// Summary of operation
// RQ1: writing data starts a transmission
// RQ2: start, data lsb first, parity, stop
// RQ3: interrupt when holding register or fifo empties
// RQ4: fcr bit 0 enables 16-deep fifos
// RQ5: transmit back to back until fifo empty
// RQ6: receiver samples at baud clock over 16
// RQ7: reject pulses shorter than two ticks
// RQ8: first data bit lands in bit 0
// RQ9: check parity and stop, report framing
// RQ10: rx interrupt on data or trigger level
// RQ11: timeout and line errors, prioritised interrupts
// RQ12: rx fifo 16 deep, trigger 1/4/8/14
// RQ13: five to eight bits, 1/1.5/2 stops
// RQ14: even, odd, sticky or no parity
// RQ15: divisor 1 to 65535
// RQ16: baud source 24 MHz or 16 MHz
// RQ17: rx timeout after four idle chars
module uwf_uart
    import uwf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire logic rxd_i,
    output logic txd_o
);

////////////////////////////////////////////////////////////////////////////////
typedef enum logic [4:0] {
    UWF_IDLE = 5'h01,
    UWF_START = 5'h02,
    UWF_DATA = 5'h04,
    UWF_PAR = 5'h08,
    UWF_STOP = 5'h10
} uwf_state_type;

function automatic logic [3:0] uwf_bits(input logic [1:0] wl);
    return 4'(5 + wl);
endfunction

logic [7:0] lcr;
logic [7:0] fcr;
logic [15:0] divisor;
logic [5:0] status;
logic [5:0] mask;
logic fifo_en;
logic [3:0] nbits;
logic req, wr, rd;
assign fifo_en = fcr[FCR_EN_BIT];
assign nbits = uwf_bits(lcr[LCR_WLEN_LSB +: 2]);
assign req = cyc_i && stb_i && !ack_o;
assign wr = req && we_i && sel_i[0];
assign rd = req && !we_i;

////////////////////////////////////////////////////////////////////////////////
// baud source: fractional accumulator gives 24 or 16 MHz enable pulses
localparam logic [27:0] INC24 = 28'(SRC24_HZ / 1000);
localparam logic [27:0] INC16 = 28'(SRC16_HZ / 1000);
localparam logic [27:0] MOD_SRC = 28'(CLK_HZ / 1000);
logic [27:0] src_acc;
logic src_tick;
logic [15:0] div_cnt;
logic tick;
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        src_acc <= '0;
        src_tick <= 1'b0;
    end else if (src_acc + (lcr[LCR_SRC16_BIT] ? INC16 : INC24) >= MOD_SRC) begin // RQ16
        src_acc <= src_acc + (lcr[LCR_SRC16_BIT] ? INC16 : INC24) - MOD_SRC;
        src_tick <= 1'b1;
    end else begin
        src_acc <= src_acc + (lcr[LCR_SRC16_BIT] ? INC16 : INC24);
        src_tick <= 1'b0;
    end
end
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        div_cnt <= '0;
        tick <= 1'b0;
    end else if (src_tick) begin
        if (div_cnt + 16'h0001 >= divisor) begin // RQ15
            div_cnt <= '0;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            tick <= 1'b0;
        end
    end else begin
        tick <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// transmit fifo (depth 1 when fifos are off acts as holding register)
logic [7:0] tx_mem [FIFO_DEPTH];
logic [FIFO_AW-1:0] tx_wp, tx_rp;
logic [FIFO_AW:0] tx_cnt;
logic tx_push, tx_pop, tx_full;
assign tx_full = fifo_en ? (tx_cnt == 5'(FIFO_DEPTH)) : (tx_cnt != 5'h00);
assign tx_push = wr && adr_i == ADDR_DATA && !tx_full; // RQ1 RQ4
always_ff @(posedge clk_i) begin
    if (rst_i || (wr && adr_i == ADDR_FCR)) begin
        tx_wp <= '0;
        tx_rp <= '0;
        tx_cnt <= '0;
    end else begin
        if (tx_push) begin
            tx_mem[tx_wp] <= dat_i[7:0];
            tx_wp <= tx_wp + 4'h1;
        end
        if (tx_pop) begin
            tx_rp <= tx_rp + 4'h1;
        end
        tx_cnt <= tx_cnt + 5'(tx_push) - 5'(tx_pop);
    end
end

////////////////////////////////////////////////////////////////////////////////
// transmitter
uwf_state_type tx_state;
logic [7:0] tx_sh;
logic [3:0] tx_os;
logic [3:0] tx_bit;
logic tx_par;
logic [5:0] tx_stop_len;
assign tx_pop = tx_state == UWF_IDLE && tx_cnt != 5'h00; // RQ5
// stop length in 16ths: 1, 1.5 for 5-bit words, else 2
assign tx_stop_len = !lcr[LCR_STOP_BIT] ? 6'd16 :
    (lcr[LCR_WLEN_LSB +: 2] == 2'b00 ? 6'd24 : 6'd32); // RQ13
logic [5:0] tx_sc;
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        tx_state <= UWF_IDLE;
        txd_o <= 1'b1;
        tx_sh <= '0;
        tx_os <= '0;
        tx_bit <= '0;
        tx_par <= 1'b0;
        tx_sc <= '0;
    end else begin
        case (tx_state)
            UWF_IDLE: begin
                txd_o <= 1'b1;
                if (tx_pop) begin // RQ1
                    tx_sh <= tx_mem[tx_rp];
                    tx_par <= 1'b0;
                    tx_os <= '0;
                    tx_state <= UWF_START;
                end
            end
            UWF_START: begin
                txd_o <= 1'b0; // RQ2
                if (tick) begin
                    tx_os <= tx_os + 4'h1;
                    if (tx_os == 4'hF) begin
                        tx_bit <= '0;
                        tx_state <= UWF_DATA;
                    end
                end
            end
            UWF_DATA: begin
                txd_o <= tx_sh[0]; // RQ2
                if (tick) begin
                    tx_os <= tx_os + 4'h1;
                    if (tx_os == 4'hF) begin
                        tx_par <= tx_par ^ tx_sh[0];
                        tx_sh <= {1'b0, tx_sh[7:1]};
                        tx_bit <= tx_bit + 4'h1;
                        if (tx_bit + 4'h1 == nbits) begin
                            tx_sc <= '0;
                            tx_state <= lcr[LCR_PEN_BIT] ? UWF_PAR : UWF_STOP;
                        end
                    end
                end
            end
            UWF_PAR: begin
                // RQ14
                txd_o <= lcr[LCR_STICK_BIT] ? !lcr[LCR_EPS_BIT]
                    : (tx_par ^ !lcr[LCR_EPS_BIT]);
                if (tick) begin
                    tx_os <= tx_os + 4'h1;
                    if (tx_os == 4'hF) begin
                        tx_state <= UWF_STOP;
                    end
                end
            end
            default: begin
                txd_o <= 1'b1;
                if (tick) begin
                    tx_sc <= tx_sc + 6'h01;
                    if (tx_sc + 6'h01 >= tx_stop_len) begin
                        tx_state <= UWF_IDLE;
                    end
                end
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// input filter: level accepted only after two stable baud ticks
logic rx_s1, rx_s2, rx_f, rx_f_d;
logic [1:0] flt_cnt;
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        rx_s1 <= 1'b1;
        rx_s2 <= 1'b1;
    end else begin
        rx_s1 <= rxd_i;
        rx_s2 <= rx_s1;
    end
end
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        rx_f <= 1'b1;
        flt_cnt <= '0;
    end else if (rx_s2 == rx_f) begin
        flt_cnt <= '0;
    end else if (tick) begin
        if (flt_cnt + 2'h1 >= 2'(FILTER_TICKS)) begin // RQ7
            rx_f <= rx_s2;
            flt_cnt <= '0;
        end else begin
            flt_cnt <= flt_cnt + 2'h1;
        end
    end
end

// start hunts for a falling edge, so a low stop bit cannot open a frame
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        rx_f_d <= 1'b1;
    end else begin
        rx_f_d <= rx_f;
    end
end

////////////////////////////////////////////////////////////////////////////////
// receiver: mid-bit sampling at tick 7 of 16
uwf_state_type rx_state;
logic [3:0] rx_os, rx_bit;
logic [7:0] rx_sh;
logic rx_par;
logic rx_done, rx_perr, rx_ferr;
logic [7:0] rx_word;
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        rx_state <= UWF_IDLE;
        rx_os <= '0;
        rx_bit <= '0;
        rx_sh <= '0;
        rx_par <= 1'b0;
        rx_done <= 1'b0;
        rx_perr <= 1'b0;
        rx_ferr <= 1'b0;
        rx_word <= '0;
    end else begin
        rx_done <= 1'b0;
        case (rx_state)
            UWF_IDLE: begin
                rx_os <= '0;
                rx_perr <= 1'b0;
                if (rx_f_d && !rx_f) begin
                    rx_state <= UWF_START;
                end
            end
            UWF_START: begin
                if (tick) begin // RQ6
                    rx_os <= rx_os + 4'h1;
                    if (rx_os == 4'h7) begin
                        rx_os <= '0;
                        rx_bit <= '0;
                        rx_par <= 1'b0;
                        rx_state <= rx_f ? UWF_IDLE : UWF_DATA;
                    end
                end
            end
            UWF_DATA: begin
                if (tick) begin
                    rx_os <= rx_os + 4'h1;
                    if (rx_os == 4'hF) begin
                        // shifts in from the top; realigned at the end
                        rx_sh <= {rx_f, rx_sh[7:1]};
                        rx_par <= rx_par ^ rx_f;
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_bit + 4'h1 == nbits) begin
                            rx_state <= lcr[LCR_PEN_BIT] ? UWF_PAR : UWF_STOP;
                        end
                    end
                end
            end
            UWF_PAR: begin
                if (tick) begin
                    rx_os <= rx_os + 4'h1;
                    if (rx_os == 4'hF) begin
                        // RQ9 RQ14
                        rx_perr <= lcr[LCR_STICK_BIT] ? (rx_f != !lcr[LCR_EPS_BIT])
                            : (rx_f != (rx_par ^ !lcr[LCR_EPS_BIT]));
                        rx_state <= UWF_STOP;
                    end
                end
            end
            default: begin
                if (tick) begin
                    rx_os <= rx_os + 4'h1;
                    if (rx_os == 4'hF) begin
                        rx_ferr <= !rx_f; // RQ9
                        rx_word <= rx_sh >> (4'h8 - nbits); // RQ8
                        rx_done <= 1'b1;
                        rx_state <= UWF_IDLE;
                    end
                end
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// receive fifo
logic [7:0] rx_mem [FIFO_DEPTH];
logic [FIFO_AW-1:0] rx_wp, rx_rp;
logic [FIFO_AW:0] rx_cnt;
logic rx_push, rx_pop, rx_overrun, rx_full;
assign rx_full = fifo_en ? (rx_cnt == 5'(FIFO_DEPTH)) : (rx_cnt != 5'h00);
assign rx_push = rx_done && !rx_full; // RQ8 RQ12
assign rx_overrun = rx_done && rx_full;
assign rx_pop = rd && adr_i == ADDR_DATA && rx_cnt != 5'h00;
always_ff @(posedge clk_i) begin
    if (rst_i || (wr && adr_i == ADDR_FCR)) begin
        rx_wp <= '0;
        rx_rp <= '0;
        rx_cnt <= '0;
    end else begin
        if (rx_push) begin
            rx_mem[rx_wp] <= rx_word;
            rx_wp <= rx_wp + 4'h1;
        end
        if (rx_pop) begin
            rx_rp <= rx_rp + 4'h1;
        end
        rx_cnt <= rx_cnt + 5'(rx_push) - 5'(rx_pop);
    end
end

////////////////////////////////////////////////////////////////////////////////
// character timeout: four characters of 16 ticks by 12 bit times
localparam logic [9:0] TIMEOUT_TICKS = 10'(TIMEOUT_CHARS * 12 * OVERSAMPLE);
logic [9:0] to_cnt;
logic to_evt;
always_ff @(posedge clk_i) begin
    if (rst_i || rx_push || rx_pop || rx_cnt == 5'h00 || !fifo_en) begin
        to_cnt <= '0;
        to_evt <= 1'b0;
    end else if (tick && to_cnt != TIMEOUT_TICKS) begin
        to_cnt <= to_cnt + 10'h001;
        to_evt <= to_cnt + 10'h001 == TIMEOUT_TICKS; // RQ17
    end else begin
        to_evt <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// events and sticky status
logic [4:0] trig;
logic rx_evt, thre_evt;
logic [4:0] tx_cnt_d;
always_comb begin
    case (fcr[FCR_TRIG_LSB +: 2])
        2'b00: trig = 5'd1;
        2'b01: trig = 5'd4;
        2'b10: trig = 5'd8;
        default: trig = 5'd14;
    endcase
end
// RQ10 RQ12
assign rx_evt = rx_push && (!fifo_en || rx_cnt + 5'h01 == trig);
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        tx_cnt_d <= '0;
    end else begin
        tx_cnt_d <= tx_cnt;
    end
end
assign thre_evt = tx_cnt == 5'h00 && tx_cnt_d != 5'h00; // RQ3
logic [5:0] evt;
always_comb begin
    evt = '0;
    evt[ST_RXDATA] = rx_evt;
    evt[ST_THRE] = thre_evt;
    evt[ST_TIMEOUT] = to_evt; // RQ11
    evt[ST_PARITY] = rx_done && rx_perr;
    evt[ST_FRAME] = rx_done && rx_ferr;
    evt[ST_OVERRUN] = rx_overrun;
end
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        status <= '0;
    end else if (wr && adr_i == ADDR_STAT) begin
        status <= (status & ~dat_i[5:0]) | evt;
    end else begin
        status <= status | evt;
    end
end
logic [5:0] pend;
logic [2:0] iid;
assign pend = status & mask;
always_comb begin
    // RQ11
    if (pend[ST_PARITY] || pend[ST_FRAME] || pend[ST_OVERRUN]) begin
        iid = IID_LINE;
    end else if (pend[ST_RXDATA]) begin
        iid = IID_RXDATA;
    end else if (pend[ST_TIMEOUT]) begin
        iid = IID_TIMEOUT;
    end else if (pend[ST_THRE]) begin
        iid = IID_THRE;
    end else begin
        iid = IID_NONE;
    end
end
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        irq_o <= 1'b0;
    end else begin
        irq_o <= pend != 6'h00;
    end
end

////////////////////////////////////////////////////////////////////////////////
// wishbone slave: one-cycle ack
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        lcr <= LCR_RESET;
        fcr <= FCR_RESET;
        divisor <= DIV_RESET;
        mask <= MASK_RESET;
    end else if (wr) begin
        if (adr_i == ADDR_LCR) begin
            lcr <= dat_i[7:0];
        end else if (adr_i == ADDR_FCR) begin
            fcr <= dat_i[7:0]; // RQ4
        end else if (adr_i == ADDR_DIV) begin
            if (sel_i[1] && dat_i[15:0] != 16'h0000) begin // RQ15
                divisor <= dat_i[15:0];
            end
        end else if (adr_i == ADDR_MASK) begin
            mask <= dat_i[5:0];
        end
    end
end
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        ack_o <= 1'b0;
        dat_o <= '0;
    end else begin
        ack_o <= req;
        dat_o <= '0;
        if (rd) begin
            if (adr_i == ADDR_DATA) begin
                dat_o <= {24'h000000, rx_cnt != 5'h00 ? rx_mem[rx_rp] : 8'h00};
            end else if (adr_i == ADDR_LCR) begin
                dat_o <= {24'h000000, lcr};
            end else if (adr_i == ADDR_FCR) begin
                dat_o <= {11'h000, rx_cnt, 3'h0, tx_cnt, fcr};
            end else if (adr_i == ADDR_DIV) begin
                dat_o <= {16'h0000, divisor};
            end else if (adr_i == ADDR_STAT) begin
                dat_o <= {26'h0000000, status};
            end else if (adr_i == ADDR_MASK) begin
                dat_o <= {26'h0000000, mask};
            end else if (adr_i == ADDR_IID) begin
                dat_o <= {29'h00000000, iid};
            end
        end
    end
end

endmodule

// File: verif/uwf_uart_checker.sv
`timescale 1ns/100ps
module uwf_uart_checker #(
    parameter int MIN_BIT = 90
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic irq_o,
    input wire logic rxd_i,
    input wire logic txd_o
);
    int low_run;
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cycles the serial output has been low so far
    always_ff @(posedge clk_i) begin
        if (rst_i || txd_o) begin
            low_run <= 0;
        end else begin
            low_run <= low_run + 1;
        end
    end
    ////////////////////////////////////////
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered");
    chk_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    chk_unmapped_zero: assert property (
        cyc_i && stb_i && !we_i && !ack_o && adr_i == 5'h1C |=> ack_o && dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_reset_idle: assert property ($fell(rst_i) |-> txd_o && !irq_o && !ack_o)
        else $error("outputs not idle after reset");
    chk_bit_length: assert property ($rose(txd_o) |-> low_run >= MIN_BIT)
        else $error("serial low stretch too short");
    chk_irq_clear: assert property (
        $fell(irq_o) |-> $past(cyc_i && stb_i && we_i, 2))
        else $error("irq fell without a write");
    cover property (ack_o && we_i);
    cover property ($rose(irq_o));
    cover property ($fell(txd_o));
    cover property ($fell(rxd_i));
endmodule
bind uwf_uart uwf_uart_checker #(.MIN_BIT(90)) u_uwf_uart_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .rxd_i(rxd_i), .txd_o(txd_o)
);

// File: verif/uwf_peer.sv
`timescale 1ns/100ps
module uwf_peer #(
    parameter int BIT = 100
) (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o
);
    logic [7:0] got [$];
    int nbits = 8;
    initial rxd_o = 1'b1;
    task automatic hold(input logic v);
        rxd_o <= v;
        repeat (BIT) @(posedge clk_i);
    endtask
    // start, data lsb first, optional parity, stop, then one idle bit
    task automatic send(input logic [7:0] d, input logic pen, input logic par,
                        input logic stp);
        hold(1'b0);
        for (int i = 0; i < 8; i++)
            hold(d[i]);
        if (pen)
            hold(par);
        hold(stp);
        hold(1'b1);
    endtask
    task automatic glitch();
        rxd_o <= 1'b0;
        @(posedge clk_i);
        rxd_o <= 1'b1;
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////
    // receiver: sample mid-bit, lsb first
    always begin
        logic [7:0] w;
        @(negedge txd_i);
        repeat (BIT / 2) @(posedge clk_i);
        w = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            repeat (BIT) @(posedge clk_i);
            w[i] = txd_i;
        end
        repeat (BIT) @(posedge clk_i);
        got.push_back(w);
    end
endmodule

// File: verif/uwf_uart_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module uwf_uart_tb;
    import uwf_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, irq, rxd, txd;
    int miscompares = 0;
    int n_compared = 0;
    int hi = 0;
    logic [7:0] lcr_t [4] = '{8'h5B, 8'h4B, 8'h7B, 8'h6B};
    logic gp_t [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    int trig_t [4] = '{1, 4, 8, 14};
    always #5 clk = ~clk;
    uwf_uart u_uwf_uart (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_o(irq),
        .rxd_i(rxd), .txd_o(txd)
    );
    uwf_peer u_uwf_peer (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
    ////////////////////////////////////////
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= 1'b1;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        logic [31:0] d;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= 1'b0;
        adr <= a;
        do @(posedge clk); while (ack !== 1'b1);
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        `CHK(nm, e & m, d & m)
    endtask
    task automatic waitq(input int n);
        for (int i = 0; i < 30000 && u_uwf_peer.got.size() < n; i++)
            @(posedge clk);
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge clk);
        miscompares++;
        $display("Error watchdog expected end seen hang");
        conclude();
    end
    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk("lcr", ADDR_LCR, 32'hFF, {24'h0, LCR_RESET});
        rchk("fcr", ADDR_FCR, 32'hFF, {24'h0, FCR_RESET});
        rchk("mask", ADDR_MASK, 32'h3F, {26'h0, MASK_RESET});
        rchk("stat", ADDR_STAT, 32'h3F, 32'h0);
        wr(5'h1C, 32'hFF);
        rchk("unmapped", 5'h1C, 32'hFFFFFFFF, 32'h0);
        wr(ADDR_DIV, 32'h0);
        rchk("div", ADDR_DIV, 32'hFFFF, {16'h0, DIV_RESET});
        wr(ADDR_LCR, 32'h43);
        wr(ADDR_DATA, 32'hA5);
        waitq(1);
        `CHK("tx_byte", 8'hA5, u_uwf_peer.got[0])
        rchk("thre", ADDR_STAT, 32'h02, 32'h02);
        `CHK("irq_masked", 1'b0, irq)
        wr(ADDR_MASK, 32'h02);
        repeat (3) @(posedge clk);
        `CHK("irq_set", 1'b1, irq)
        wr(ADDR_STAT, 32'h02);
        repeat (3) @(posedge clk);
        `CHK("irq_clr", 1'b0, irq)
        wr(ADDR_MASK, 32'h0);
        $display("test basic done");
        wr(ADDR_FCR, 32'h01);
        u_uwf_peer.got.delete();
        for (int i = 0; i < 18; i++)
            wr(ADDR_DATA, i);
        waitq(17);
        repeat (1500) @(posedge clk);
        `CHK("tx_fill", 17, u_uwf_peer.got.size())
        for (int i = 0; i < 17; i++)
            `CHK("tx_order", 8'(i), u_uwf_peer.got[i])
        wr(ADDR_FCR, 32'h0);
        wr(ADDR_LCR, 32'h40);
        u_uwf_peer.nbits = 5;
        u_uwf_peer.got.delete();
        wr(ADDR_DATA, 32'hF3);
        waitq(1);
        `CHK("tx_5bit", 8'h13, u_uwf_peer.got[0])
        u_uwf_peer.nbits = 8;
        // two stop bits at 24 MHz source over 3: 32 ticks of 12.5 clocks
        wr(ADDR_FCR, 32'h01);
        wr(ADDR_DIV, 32'h3);
        wr(ADDR_LCR, 32'h07);
        wr(ADDR_DATA, 32'h0);
        wr(ADDR_DATA, 32'h0);
        while (txd !== 1'b0)
            @(posedge clk);
        while (txd !== 1'b1)
            @(posedge clk);
        while (txd === 1'b1 && hi < 800) begin
            hi++;
            @(posedge clk);
        end
        `CHK("stop_time", 1'b1, hi >= 395 && hi <= 410)
        wr(ADDR_FCR, 32'h0);
        wr(ADDR_DIV, 32'h1);
        wr(ADDR_LCR, 32'h43);
        $display("test transmit done");
        u_uwf_peer.send(8'h3C, 1'b0, 1'b0, 1'b1);
        rchk("rx_flag", ADDR_STAT, 32'h01, 32'h01);
        rchk("rx_byte", ADDR_DATA, 32'hFF, 32'h3C);
        wr(ADDR_STAT, 32'h3F);
        u_uwf_peer.glitch();
        repeat (300) @(posedge clk);
        rchk("glitch", ADDR_STAT, 32'h11, 32'h0);
        u_uwf_peer.send(8'h55, 1'b0, 1'b0, 1'b0);
        rchk("frame", ADDR_STAT, 32'h10, 32'h10);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_FCR, 32'h0);
            wr(ADDR_LCR, {24'h0, lcr_t[k]});
            wr(ADDR_STAT, 32'h3F);
            u_uwf_peer.send(8'h07, 1'b1, gp_t[k], 1'b1);
            rchk("par_good", ADDR_STAT, 32'h08, 32'h0);
            rchk("par_data", ADDR_DATA, 32'hFF, 32'h07);
            u_uwf_peer.send(8'h07, 1'b1, ~gp_t[k], 1'b1);
            rchk("par_bad", ADDR_STAT, 32'h08, 32'h08);
        end
        wr(ADDR_LCR, 32'h43);
        $display("test receive done");
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_FCR, {24'h0, t[1:0], 6'h01});
            wr(ADDR_STAT, 32'h3F);
            wr(ADDR_MASK, 32'h01);
            for (int i = 0; i < trig_t[t] - 1; i++)
                u_uwf_peer.send(8'h30 + 8'(i), 1'b0, 1'b0, 1'b1);
            `CHK("irq_below", 1'b0, irq)
            u_uwf_peer.send(8'h30 + 8'(trig_t[t] - 1), 1'b0, 1'b0, 1'b1);
            `CHK("irq_at", 1'b1, irq)
        end
        rchk("rx_count", ADDR_FCR, 32'h1F0000, 32'h0E0000);
        wr(ADDR_MASK, 32'h05);
        repeat (6000) @(posedge clk);
        rchk("timeout", ADDR_STAT, 32'h04, 32'h04);
        rchk("iid", ADDR_IID, 32'h7, {29'h0, IID_RXDATA});
        rchk("rx_first", ADDR_DATA, 32'hFF, 32'h30);
        $display("test fifo receive done");
        conclude();
    end
endmodule
